// [rtl/rosc_pkg.sv]
package rosc_pkg;

  // Receive framing format, one-hot
  typedef enum logic [3:0] {
    FMT_M13  = 4'b0001,
    FMT_CBIT = 4'b0010,
    FMT_G751 = 4'b0100,
    FMT_G832 = 4'b1000
  } rosc_fmt_t;

  // Register byte addresses
  localparam logic [7:0] ADDR_ALARM_BYTE   = 8'h00;
  localparam logic [7:0] ADDR_ALARM_STACK  = 8'h01;
  localparam logic [7:0] ADDR_ALARM_STATUS = 8'h02;
  localparam logic [7:0] ADDR_APP_ID       = 8'h03;
  localparam logic [7:0] ADDR_CNT_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_CNT_INT_EN   = 8'h05;
  localparam logic [7:0] ADDR_GEN_STATUS   = 8'h06;
  localparam logic [7:0] ADDR_CNT_BASE     = 8'h10; // Counter i byte b at base + 4*i + b

  // Field positions
  localparam int STK_VALID_BIT = 1;
  localparam int STK_MORE_BIT  = 0;
  localparam int STS_NE_BIT    = 2;
  localparam int STS_IDLE_BIT  = 1;
  localparam int STS_ITR_BIT   = 0;

  // Counters
  localparam int NUM_CNT  = 8;
  localparam int CNT_PAR  = 0;
  localparam int CNT_DGR  = 1;
  localparam int CNT_LCV  = 7;
  localparam logic [23:0] CNT_MAX_16 = 24'h00ffff;
  localparam logic [23:0] CNT_MAX_24 = 24'hffffff;
  localparam logic [7:0]  CNT_INT_EN_RESET = 8'h00;

  // Alarm code stack
  localparam int STACK_DEPTH = 4;
  localparam int STACK_PW    = 2;

  // Timing
  localparam longint CLK_PERIOD_PS = 4000;
  localparam longint ONE_SEC_PS    = 1000000000000;
  localparam longint ONE_SEC_CYC   = ONE_SEC_PS / CLK_PERIOD_PS;

endpackage : rosc_pkg

// [rtl/rosc_rx_overhead.sv]
module rosc_rx_overhead
  import rosc_pkg::*;
#(
  parameter logic [27:0] ONE_SEC_CYCLES = 28'(ONE_SEC_CYC)
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // Channel setup
  input  wire logic        chanEn,
  input  wire rosc_fmt_t   rxFormat,
  input  wire logic        repetitiveMode,
  // Alarm channel from the receiver
  input  wire logic        alarmBitStb,
  input  wire logic        alarmBit,
  input  wire logic        alarmMsgDetect,
  input  wire logic        stackPush,
  input  wire logic [5:0]  stackCode,
  input  wire logic        idleCodeStb,
  // Application-id bit, one per frame
  input  wire logic        appIdStb,
  input  wire logic        appIdBit,
  // Parity sources
  input  wire logic        mframeStb,
  input  wire logic        parityMismatch,
  input  wire logic        pBitA,
  input  wire logic        pBitB,
  input  wire logic        frameStb,
  input  wire logic        bipMismatch,
  // Other error events, counters 2..7
  input  wire logic [7:2]  errEvt,
  // Microprocessor register port
  input  wire logic [7:0]  busAddr,
  input  wire logic        busRd,
  input  wire logic        busWr,
  input  wire logic [7:0]  busWrData,
  output logic      [7:0]  busRdData,
  // Interrupt and timer
  output logic             interruptRequestN,
  output logic             oneSecTick
);

  // Saturation point of a counter
  function automatic logic [23:0] cntMax(input int idx);
    cntMax = (idx == CNT_LCV) ? CNT_MAX_24 : CNT_MAX_16;
  endfunction : cntMax

  // Address hit on a counter byte
  function automatic logic cntHit(input logic [7:0] a, input int idx, input int b);
    cntHit = (a == 8'(ADDR_CNT_BASE + 4 * idx + b));
  endfunction : cntHit

  logic              cbit;
  logic              chanEnD;
  logic              chanEnRise;
  logic [7:0]        alarmShift;
  logic [2:0]        alarmBitCnt;
  logic              alarmLoad;
  logic [7:0]        receivedAlarmCodeByte_reg;
  logic [5:0]        stackMem [STACK_DEPTH];
  logic [STACK_PW-1:0] stackRdPtr;
  logic [STACK_PW-1:0] stackWrPtr;
  logic [STACK_PW:0] stackCount;
  logic              stackPop;
  logic              stackCodeValid;
  logic              stackMorePending;
  logic              stackNotEmpty;
  logic              legalSeen;
  logic              alarmChannelIdle_reg;
  logic              alarmByteInterrupt_reg;
  logic [7:0]        appIdShift;
  logic [2:0]        appIdCnt;
  logic [7:0]        appIdChannelByte_reg;
  logic [23:0]       cnt_reg [NUM_CNT];
  logic [15:0]       cntHold_reg [NUM_CNT];
  logic [NUM_CNT-1:0] cntEvt;
  logic [NUM_CNT-1:0] cntRdLow;
  logic [NUM_CNT-1:0] cntStatus_reg;
  logic [NUM_CNT-1:0] cntStatusSet;
  logic [7:0]        cntIntEn_reg;
  logic [27:0]       one_second_interval_timer_reg;
  logic              oneSecFlag_reg;
  logic              rdByte;
  logic              rdStack;
  logic              rdStatus;
  logic              rdCntStatus;
  logic              rdGen;
  logic [7:0]        rdData_next;

  assign cbit       = (rxFormat == FMT_CBIT);
  assign chanEnRise = chanEn & ~chanEnD;

  // Read strobes that carry side effects
  assign rdByte      = busRd && busAddr == ADDR_ALARM_BYTE;
  assign rdStack     = busRd && busAddr == ADDR_ALARM_STACK;
  assign rdStatus    = busRd && busAddr == ADDR_ALARM_STATUS;
  assign rdCntStatus = busRd && busAddr == ADDR_CNT_STATUS;
  assign rdGen       = busRd && busAddr == ADDR_GEN_STATUS;

  // Channel enable edge, used to reinitialise the stack flags
  always_ff @(posedge clk) begin
    if (!nrst) begin
      chanEnD <= 1'b0;
    end else if (ce) begin
      chanEnD <= chanEn;
    end
  end

  // Alarm byte assembly: bits enter from the top so the first lands in bit 0
  assign alarmLoad = cbit && alarmBitStb && alarmBitCnt == 3'h7;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      alarmShift                <= 8'h00;
      alarmBitCnt               <= 3'h0;
      receivedAlarmCodeByte_reg <= 8'h00;
    end else if (ce && cbit && alarmBitStb) begin
      alarmShift  <= {alarmBit, alarmShift[7:1]};
      alarmBitCnt <= alarmBitCnt + 3'h1;
      if (alarmLoad) begin
        receivedAlarmCodeByte_reg <= {alarmBit, alarmShift[7:1]};
      end
    end
  end

  // Alarm-byte interrupt; a set in the read cycle wins over the clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      alarmByteInterrupt_reg <= 1'b0;
    end else if (ce) begin
      if ((!repetitiveMode && alarmLoad) || (repetitiveMode && cbit && alarmMsgDetect)) begin
        alarmByteInterrupt_reg <= 1'b1;
      end else if (rdByte) begin
        alarmByteInterrupt_reg <= 1'b0;
      end
    end
  end

  // Code word queue; code bits carry no reset, only pointers do
  assign stackPop         = rdStack && stackCount != '0;
  assign stackCodeValid   = stackCount != '0;
  assign stackMorePending = stackCount > (STACK_PW + 1)'(1);
  assign stackNotEmpty    = stackCodeValid;
  always_ff @(posedge clk) begin
    if (ce && stackPush && (stackCount != (STACK_PW + 1)'(STACK_DEPTH) || stackPop)) begin
      stackMem[stackWrPtr] <= stackCode;
    end
  end

  // Queue pointers; words arriving when full are dropped unless a pop frees a slot in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stackRdPtr <= '0;
      stackWrPtr <= '0;
      stackCount <= '0;
    end else if (ce) begin
      if (chanEnRise) begin
        stackRdPtr <= '0;
        stackWrPtr <= '0;
        stackCount <= '0;
      end else begin
        if (stackPush && (stackCount != (STACK_PW + 1)'(STACK_DEPTH) || stackPop)) begin
          stackWrPtr <= stackWrPtr + 1'b1;
        end
        if (stackPop) begin
          stackRdPtr <= stackRdPtr + 1'b1;
        end
        if (stackPush && !stackPop && stackCount != (STACK_PW + 1)'(STACK_DEPTH)) begin
          stackCount <= stackCount + 1'b1;
        end else if (stackPop && !stackPush) begin
          stackCount <= stackCount - 1'b1;
        end
      end
    end
  end

  // Idle detection only after at least one legal code word
  always_ff @(posedge clk) begin
    if (!nrst) begin
      legalSeen            <= 1'b0;
      alarmChannelIdle_reg <= 1'b0;
    end else if (ce) begin
      if (stackPush) begin
        legalSeen <= 1'b1;
      end else if (idleCodeStb) begin
        legalSeen <= 1'b0;
      end
      if (cbit && idleCodeStb && legalSeen) begin
        alarmChannelIdle_reg <= 1'b1;
      end else if (rdStatus) begin
        alarmChannelIdle_reg <= 1'b0;
      end
    end
  end

  // Application-id byte from eight frames, earliest bit in bit 0
  always_ff @(posedge clk) begin
    if (!nrst) begin
      appIdShift           <= 8'h00;
      appIdCnt             <= 3'h0;
      appIdChannelByte_reg <= 8'h00;
    end else if (ce && cbit && appIdStb) begin
      appIdShift <= {appIdBit, appIdShift[7:1]};
      appIdCnt   <= appIdCnt + 3'h1;
      if (appIdCnt == 3'h7) begin
        appIdChannelByte_reg <= {appIdBit, appIdShift[7:1]};
      end
    end
  end

  // Counter increment sources
  always_comb begin
    cntEvt         = {errEvt, 2'b00};
    cntEvt[CNT_PAR] = (rxFormat != FMT_G751 && rxFormat != FMT_G832 && mframeStb
                       && (parityMismatch || (pBitA != pBitB)))
                      || (rxFormat == FMT_G832 && frameStb && bipMismatch);
    cntEvt[CNT_DGR] = mframeStb && (pBitA != pBitB);
  end

  // Low-byte reads of each counter
  always_comb begin
    for (int i = 0; i < NUM_CNT; i++) begin
      cntRdLow[i] = busRd && cntHit(busAddr, i, 0);
    end
  end

  // Counters: clear on low-byte read, saturate or wrap per interrupt enable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        cnt_reg[i]     <= 24'h000000;
        cntHold_reg[i] <= 16'h0000;
      end
    end else if (ce) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        if (cntRdLow[i]) begin
          cntHold_reg[i] <= cnt_reg[i][23:8];
          cnt_reg[i]     <= {23'h000000, cntEvt[i]};
        end else if (cntEvt[i]) begin
          if (cnt_reg[i] != cntMax(i)) begin
            cnt_reg[i] <= cnt_reg[i] + 24'h000001;
          end else if (cntIntEn_reg[i]) begin
            cnt_reg[i] <= 24'h000000;
          end
        end
      end
    end
  end

  // Overflow indication: saturation and wrap share the status bit
  always_comb begin
    for (int i = 0; i < NUM_CNT; i++) begin
      cntStatusSet[i] = cntEvt[i] && !cntRdLow[i] && cnt_reg[i] == cntMax(i);
    end
  end

  // Counter status and enable; set wins over the read clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cntStatus_reg <= 8'h00;
      cntIntEn_reg  <= CNT_INT_EN_RESET;
    end else if (ce) begin
      cntStatus_reg <= (rdCntStatus ? 8'h00 : cntStatus_reg) | cntStatusSet;
      if (busWr && busAddr == ADDR_CNT_INT_EN) begin
        cntIntEn_reg <= busWrData;
      end
    end
  end

  // Interrupt pin for set status bits of enabled counters, i.e. the wrapping ones; saturating counters raise none
  always_ff @(posedge clk) begin
    if (!nrst) begin
      interruptRequestN <= 1'b1;
    end else if (ce) begin
      interruptRequestN <= ~|(cntStatus_reg & cntIntEn_reg);
    end
  end

  // One-second interval timer; valid only with saturating counters
  always_ff @(posedge clk) begin
    if (!nrst) begin
      one_second_interval_timer_reg     <= 28'h0000000;
      oneSecTick     <= 1'b0;
      oneSecFlag_reg <= 1'b0;
    end else if (ce) begin
      oneSecTick <= 1'b0;
      if (one_second_interval_timer_reg == ONE_SEC_CYCLES - 28'h0000001) begin
        one_second_interval_timer_reg     <= 28'h0000000;
        oneSecTick     <= 1'b1;
        oneSecFlag_reg <= 1'b1;
      end else begin
        one_second_interval_timer_reg <= one_second_interval_timer_reg + 28'h0000001;
        if (rdGen) begin
          oneSecFlag_reg <= 1'b0;
        end
      end
    end
  end

  // Read mux; unmapped addresses return zero
  always_comb begin
    rdData_next = 8'h00;
    case (busAddr)
      ADDR_ALARM_BYTE:   rdData_next = receivedAlarmCodeByte_reg;
      ADDR_ALARM_STACK:  rdData_next = {stackMem[stackRdPtr], stackCodeValid, stackMorePending};
      ADDR_ALARM_STATUS: rdData_next = {5'h00, stackNotEmpty, alarmChannelIdle_reg,
                                        alarmByteInterrupt_reg};
      ADDR_APP_ID:       rdData_next = appIdChannelByte_reg;
      ADDR_CNT_STATUS:   rdData_next = cntStatus_reg;
      ADDR_CNT_INT_EN:   rdData_next = cntIntEn_reg;
      ADDR_GEN_STATUS:   rdData_next = {7'h00, oneSecFlag_reg};
      default: begin
        for (int i = 0; i < NUM_CNT; i++) begin
          if (cntHit(busAddr, i, 0)) rdData_next = cnt_reg[i][7:0];
          if (cntHit(busAddr, i, 1)) rdData_next = cntHold_reg[i][7:0];
          if (i == CNT_LCV && cntHit(busAddr, i, 2)) rdData_next = cntHold_reg[i][15:8];
        end
      end
    endcase
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busRdData <= 8'h00;
    end else if (ce && busRd) begin
      busRdData <= rdData_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_stack_valid_set: assert property (
    ce && stackPush && stackCount == '0 && !chanEnRise |=> stackCodeValid)
    else $error("stack valid not set after first push");
  chk_stack_more_set: assert property (
    ce && stackPush && stackCount == (STACK_PW + 1)'(1) && !stackPop && !chanEnRise
    |=> stackMorePending)
    else $error("more flag missing with two words queued");
  chk_enable_clears: assert property (
    ce && chanEnRise && !stackPush |=> !stackCodeValid && !stackMorePending)
    else $error("stack flags not cleared on enable");
  chk_idle_read_clear: assert property (
    ce && rdStatus && !(cbit && idleCodeStb && legalSeen) |=> !alarmChannelIdle_reg)
    else $error("idle bit survived status read");
  chk_itr_read_clear: assert property (
    ce && rdByte && !alarmLoad && !(repetitiveMode && alarmMsgDetect)
    |=> !alarmByteInterrupt_reg)
    else $error("alarm interrupt survived byte read");
  // Overflow checks for every counter, saturating and wrapping alike
  for (genvar g = 0; g < NUM_CNT; g++) begin : gCntChk
    chk_cnt_saturate: assert property (
      ce && cntEvt[g] && cnt_reg[g] == cntMax(g) && !cntIntEn_reg[g] && !cntRdLow[g]
      |=> cnt_reg[g] == cntMax(g) && cntStatus_reg[g])
      else $error("counter did not saturate with status");
    chk_cnt_wrap_int: assert property (
      ce && cntEvt[g] && cnt_reg[g] == cntMax(g) && cntIntEn_reg[g] && !cntRdLow[g]
      |=> cnt_reg[g] == 24'h000000 ##1 (!ce || !interruptRequestN))
      else $error("wrap did not raise interrupt");
  end
  chk_read_no_loss: assert property (
    ce && cntRdLow[CNT_PAR] && cntEvt[CNT_PAR] |=> cnt_reg[CNT_PAR] == 24'h000001)
    else $error("event during read lost");
  chk_disagree_count: assert property (
    ce && mframeStb && pBitA != pBitB && !cntRdLow[CNT_DGR] && cnt_reg[CNT_DGR] != CNT_MAX_16
    |=> cnt_reg[CNT_DGR] == $past(cnt_reg[CNT_DGR]) + 24'h000001)
    else $error("disagree counter did not step");
  chk_status_read_clear: assert property (
    ce && rdCntStatus |=> cntStatus_reg == $past(cntStatusSet))
    else $error("counter status survived its read");
  chk_irq_follows: assert property (
    ce && |(cntStatus_reg & cntIntEn_reg) |=> !interruptRequestN)
    else $error("interrupt pin not driven for enabled overflow");

endmodule : rosc_rx_overhead

// [tb/rosc_host_model.sv]
module rosc_host_model (
  // Bus clock
  input  wire logic       clk,
  // Register port
  output logic      [7:0] busAddr,
  output logic            busRd,
  output logic            busWr,
  output logic      [7:0] busWrData,
  input  wire logic [7:0] busRdData
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    busAddr = 8'h00;
    busRd = 1'b0;
    busWr = 1'b0;
    busWrData = 8'h00;
  end

  // Read: strobe taken at one edge, data settled by the next fall
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    busAddr = a;
    busRd = 1'b1;
    @(negedge clk);
    busRd = 1'b0;
    d = busRdData;
    busAddr = ~a; // Released lines must not hold the old address
  endtask : rd

  // Write: takes effect at the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    busAddr = a;
    busWrData = v;
    busWr = 1'b1;
    @(negedge clk);
    busWr = 1'b0;
    busAddr = ~a;
    busWrData = ~v;
  endtask : wr

  // Low byte first, so the high byte comes from the snapshot
  task automatic rdCnt(input logic [7:0] a, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo);
    rd(a + 8'h01, hi);
    v = {hi, lo};
  endtask : rdCnt
endmodule : rosc_host_model

// [tb/tb_rosc_rx_overhead.sv]
module tb_rosc_rx_overhead
  import rosc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus, all given at time zero
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       chanEn = 1'b0;
  rosc_fmt_t  rxFormat = FMT_CBIT;
  logic       repMode = 1'b0;
  logic       aStb = 1'b0, aBit = 1'b0, msgDet = 1'b0;
  logic       push = 1'b0, idleStb = 1'b0, appStb = 1'b0, appBit = 1'b0;
  logic [5:0] code = 6'h00;
  logic       mfStb = 1'b0, parMis = 1'b0, pA = 1'b0, pB = 1'b0;
  logic       frStb = 1'b0, bipMis = 1'b0;
  logic [7:2] errEvt = 6'h00;
  logic [7:0] busAddr, busWrData, busRdData, d;
  logic       busRd, busWr, irqN, tick;
  logic [15:0] w;
  int         failures = 0;
  int         totalChecks = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  rosc_host_model i_host (.clk(clk), .busAddr(busAddr), .busRd(busRd), .busWr(busWr),
    .busWrData(busWrData), .busRdData(busRdData));

  // Short second keeps the timer test brief
  rosc_rx_overhead #(.ONE_SEC_CYCLES(28'd16)) i_dut (.clk(clk), .nrst(nrst), .ce(1'b1),
    .chanEn(chanEn), .rxFormat(rxFormat), .repetitiveMode(repMode), .alarmBitStb(aStb),
    .alarmBit(aBit), .alarmMsgDetect(msgDet), .stackPush(push), .stackCode(code),
    .idleCodeStb(idleStb), .appIdStb(appStb), .appIdBit(appBit), .mframeStb(mfStb),
    .parityMismatch(parMis), .pBitA(pA), .pBitB(pB), .frameStb(frStb),
    .bipMismatch(bipMis), .errEvt(errEvt), .busAddr(busAddr), .busRd(busRd),
    .busWr(busWr), .busWrData(busWrData), .busRdData(busRdData),
    .interruptRequestN(irqN), .oneSecTick(tick));

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
    totalChecks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string what);
    i_host.rd(a, d);
    chk(24'(d), 24'(exp), what);
  endtask : rdChk

  task automatic stopTest;
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stopTest

  // Reset values, access kinds and an unmapped address
  task automatic tReset;
    chk(24'(irqN), 24'h1, "irqN");
    rdChk(ADDR_ALARM_STATUS, 8'h00, "status");
    rdChk(ADDR_CNT_STATUS, 8'h00, "cntStatus");
    rdChk(ADDR_CNT_INT_EN, CNT_INT_EN_RESET, "intEn");
    rdChk(ADDR_CNT_BASE, 8'h00, "parCnt");
    rdChk(ADDR_CNT_BASE + 8'h04, 8'h00, "dgrCnt");
    rdChk(8'h0f, 8'h00, "unmapped");
    i_host.wr(ADDR_CNT_INT_EN, 8'h5a);
    rdChk(ADDR_CNT_INT_EN, 8'h5a, "intEnRw");
    i_host.wr(ADDR_ALARM_STATUS, 8'hff);
    rdChk(ADDR_ALARM_STATUS, 8'h00, "statusRo");
    i_host.wr(ADDR_CNT_INT_EN, 8'h00);
  endtask : tReset

  // Eight alarm bits back to back, then repetitive detect
  task automatic tAlarm;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      aStb = 1'b1;
      aBit = 1'(8'h5a >> i);
    end
    @(negedge clk);
    aStb = 1'b0;
    rdChk(ADDR_ALARM_STATUS, 8'h01, "itrSingle");
    rdChk(ADDR_ALARM_STATUS, 8'h01, "itrKept");
    rdChk(ADDR_ALARM_BYTE, 8'h5a, "alarmByte");
    rdChk(ADDR_ALARM_STATUS, 8'h00, "itrCleared");
    repMode = 1'b1;
    @(negedge clk);
    msgDet = 1'b1;
    @(negedge clk);
    msgDet = 1'b0;
    rdChk(ADDR_ALARM_STATUS, 8'h01, "itrRepeat");
    rdChk(ADDR_ALARM_BYTE, 8'h5a, "alarmByte2");
    rdChk(ADDR_ALARM_STATUS, 8'h00, "itrCleared2");
    repMode = 1'b0;
  endtask : tAlarm

  // Two words queued, idle code, pops, then enable flushes
  task automatic tStack;
    @(negedge clk);
    push = 1'b1;
    code = 6'h2a;
    @(negedge clk);
    code = 6'h15;
    @(negedge clk);
    push = 1'b0;
    rdChk(ADDR_ALARM_STATUS, 8'h04, "notEmpty");
    idleStb = 1'b1;
    @(negedge clk);
    idleStb = 1'b0;
    rdChk(ADDR_ALARM_STATUS, 8'h06, "idleSet");
    rdChk(ADDR_ALARM_STATUS, 8'h04, "idleCleared");
    rdChk(ADDR_ALARM_STACK, 8'hab, "stackFirst");
    rdChk(ADDR_ALARM_STACK, 8'h56, "stackLast");
    i_host.rd(ADDR_ALARM_STACK, d);
    chk(24'(d[1:0]), 24'h0, "stackDrained");
    rdChk(ADDR_ALARM_STATUS, 8'h00, "empty");
    push = 1'b1;
    chanEn = 1'b0;
    @(negedge clk);
    push = 1'b0;
    chanEn = 1'b1;
    @(negedge clk);
    i_host.rd(ADDR_ALARM_STACK, d);
    chk(24'(d[1:0]), 24'h0, "stackOnEnable");
    rdChk(ADDR_ALARM_STATUS, 8'h00, "statusOnEnable");
    // Five words into a four-deep queue: the fifth is dropped
    for (int i = 1; i < 6; i++) begin
      @(negedge clk);
      push = 1'b1;
      code = 6'(i);
    end
    @(negedge clk);
    push = 1'b0;
    for (int i = 1; i < 5; i++) begin
      rdChk(ADDR_ALARM_STACK, {6'(i), 1'b1, 1'(i < 4)}, "stackFull");
    end
    rdChk(ADDR_ALARM_STATUS, 8'h00, "fullDrained");
  endtask : tStack

  // Application-id bits, pattern not its own mirror
  task automatic tAppId;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      appStb = 1'b1;
      appBit = 1'(8'h1e >> i);
    end
    @(negedge clk);
    appStb = 1'b0;
    rdChk(ADDR_APP_ID, 8'h1e, "appId");
  endtask : tAppId

  // Parity sources per format, and an event racing a read
  task automatic tParity;
    rxFormat = FMT_M13;
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      mfStb = 1'b1;
      parMis = (i < 3);
      pA = (i >= 3);
    end
    @(negedge clk);
    mfStb = 1'b0;
    parMis = 1'b0;
    pA = 1'b0;
    i_host.rdCnt(ADDR_CNT_BASE, w);
    chk(24'(w), 24'h5, "parCount");
    i_host.rdCnt(ADDR_CNT_BASE + 8'h04, w);
    chk(24'(w), 24'h2, "dgrCount");
    rdChk(ADDR_CNT_BASE, 8'h00, "parCleared");
    rxFormat = FMT_G751;
    {mfStb, parMis, frStb, bipMis} = 4'hf;
    @(negedge clk);
    {mfStb, frStb} = 2'b00;
    rdChk(ADDR_CNT_BASE, 8'h00, "parG751");
    rxFormat = FMT_G832;
    parMis = 1'b0;
    frStb = 1'b1;
    repeat (2) @(negedge clk);
    frStb = 1'b0;
    fork
      i_host.rd(ADDR_CNT_BASE, d);
      begin
        @(negedge clk);
        frStb = 1'b1;
        @(negedge clk);
        frStb = 1'b0;
      end
    join
    chk(24'(d), 24'h2, "bipCount");
    rdChk(ADDR_CNT_BASE, 8'h01, "raceKept");
    bipMis = 1'b0;
  endtask : tParity

  // One counter saturates, its neighbour wraps, line-code counter passes 16 bits
  task automatic tSat;
    i_host.wr(ADDR_CNT_INT_EN, 8'h08);
    @(negedge clk);
    errEvt = 6'h23;
    repeat (65537) @(negedge clk);
    errEvt = 6'h00;
    @(negedge clk);
    chk(24'(irqN), 24'h0, "irqLow");
    i_host.rdCnt(ADDR_CNT_BASE + 8'h08, w);
    chk(24'(w), 24'h00ffff, "saturated");
    i_host.rdCnt(ADDR_CNT_BASE + 8'h0c, w);
    chk(24'(w), 24'h000001, "wrapped");
    i_host.rdCnt(ADDR_CNT_BASE + 8'h1c, w);
    chk(24'(w), 24'h000001, "lcvLow");
    rdChk(ADDR_CNT_BASE + 8'h1e, 8'h01, "lcvTop");
    rdChk(ADDR_CNT_BASE + 8'h0f, 8'h00, "padByte");
    rdChk(ADDR_CNT_STATUS, 8'h0c, "cntFlags");
    @(negedge clk);
    chk(24'(irqN), 24'h1, "irqCleared");
    rdChk(ADDR_CNT_STATUS, 8'h00, "cntFlagsClr");
    i_host.wr(ADDR_CNT_INT_EN, 8'h00);
  endtask : tSat

  // Timer wrap with every counter left saturating
  task automatic tOneSec;
    int n;
    n = 0;
    while (tick !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 100) begin
      failures++;
      stopTest();
    end else begin
      rdChk(ADDR_GEN_STATUS, 8'h01, "secFlag");
      rdChk(ADDR_GEN_STATUS, 8'h00, "secCleared");
    end
  endtask : tOneSec

  // Reset for four cycles, then each scenario in turn
  initial begin
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    chanEn = 1'b1;
    tReset();
    tAlarm();
    tStack();
    tAppId();
    tParity();
    tSat();
    tOneSec();
    stopTest();
  end
endmodule : tb_rosc_rx_overhead
